//--- pkg/irq_prio_map.svh
// Offsets, reset values and field positions of the enable registers.
// Assumes inclusion by bare name, once per compilation unit.
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH
// Printed offsets are register indices; byte address is index times four
`define G0_HIGH_INDEX 12'hfc1
`define G0_LOW_INDEX 12'hfc2
`define G1_HIGH_INDEX 12'hfc4
`define G1_LOW_INDEX 12'hfc5
`define REQ_INDEX 12'hfc0
`define CTRL_INDEX 12'hfc3
`define ENABLE_RESET 8'h00
`define DAC_BIT 3'h6
`define G1_WRITE_MASK 8'hbf
`define DMA1_BIT 3'h5
`define DMA0_BIT 3'h4
`define CTRL_GIE_BIT 5'h00
`endif

//--- pkg/irq_prio_pkg.sv
// Types shared by the enable/priority block.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_prio_pkg;
  typedef enum logic [1:0] {
    prio_off = 2'b00,
    prio_low = 2'b01,
    prio_nominal = 2'b10,
    prio_high = 2'b11
  } prio_t;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_write = 2'b01,
    bus_read = 2'b10
  } bus_phase_t;
endpackage : irq_prio_pkg

//--- verilog/irq_enable_priority_regs.sv
// Interrupt enable/priority registers for request groups 0 and 1, with arbitration.
// Assumes an AHB-Lite master on clk, request lines synchronous to clk.
`timescale 1ns/100ps
`include "irq_prio_map.svh"

module irq_enable_priority_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] request_group0,
  input wire logic [7:0] request_group1,
  output logic [15:0] prio_group0,
  output logic [15:0] prio_group1,
  output logic irq_valid,
  output logic [3:0] irq_source,
  output logic [1:0] irq_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_sync1;
  logic rst_sync2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end
  wire logic rst_core_n = rst_sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic irq_prio_pkg::prio_t decode_prio(input logic hi, input logic lo);
    decode_prio = irq_prio_pkg::prio_t'({hi, lo});
  endfunction : decode_prio

  // Winner of one group of eight: {found, index, level}; lower index wins ties
  function automatic logic [5:0] pick_best(input logic [7:0] req, input logic [15:0] prio);
    logic [5:0] best;
    logic [1:0] lvl;
    best = 6'h00;
    lvl = 2'b00;
    for (int x = 7; x >= 0; x--) begin
      lvl = req[x] ? prio[2*x +: 2] : 2'b00;
      if (lvl != 2'b00 && lvl >= best[1:0]) begin
        best = {1'b1, 3'(x), lvl};
      end
    end
    pick_best = best;
  endfunction : pick_best

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic [7:0] group0_enable_high;
  logic [7:0] group0_enable_low;
  logic [7:0] group1_enable_high;
  logic [7:0] group1_enable_low;
  logic global_enable;
  irq_prio_pkg::bus_phase_t phase;
  logic [11:0] phase_index;

  wire logic take = hsel && hready && htrans[1];
  wire logic [11:0] addr_index = haddr[13:2];
  wire irq_prio_pkg::bus_phase_t next_phase =
    !take ? irq_prio_pkg::bus_idle :
    (hwrite ? irq_prio_pkg::bus_write : irq_prio_pkg::bus_read);

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      phase <= irq_prio_pkg::bus_idle;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      phase_index <= 12'h000;
    end else begin
      phase_index <= addr_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  wire logic wr = (phase == irq_prio_pkg::bus_write);
  wire logic wr_g0h = wr && (phase_index == `G0_HIGH_INDEX);
  wire logic wr_g0l = wr && (phase_index == `G0_LOW_INDEX);
  wire logic wr_g1h = wr && (phase_index == `G1_HIGH_INDEX);
  wire logic wr_g1l = wr && (phase_index == `G1_LOW_INDEX);
  wire logic wr_ctrl = wr && (phase_index == `CTRL_INDEX);
  // Dac bit keeps its stored value; only the writable bits take new data
  wire logic [7:0] g1_mask = `G1_WRITE_MASK;
  wire logic [7:0] next_g1h = (hwdata[7:0] & g1_mask) | (group1_enable_high & ~g1_mask);
  wire logic [7:0] next_g1l = (hwdata[7:0] & g1_mask) | (group1_enable_low & ~g1_mask);

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      group0_enable_high <= `ENABLE_RESET;
    end else if (wr_g0h) begin
      group0_enable_high <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      group0_enable_low <= `ENABLE_RESET;
    end else if (wr_g0l) begin
      group0_enable_low <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      group1_enable_high <= `ENABLE_RESET;
    end else if (wr_g1h) begin
      group1_enable_high <= next_g1h;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      group1_enable_low <= `ENABLE_RESET;
    end else if (wr_g1l) begin
      group1_enable_low <= next_g1l;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      global_enable <= 1'b0;
    end else if (wr_ctrl) begin
      global_enable <= hwdata[`CTRL_GIE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  wire logic rd = (next_phase == irq_prio_pkg::bus_read);
  wire logic hit_g0h = (addr_index == `G0_HIGH_INDEX);
  wire logic hit_g0l = (addr_index == `G0_LOW_INDEX);
  wire logic hit_g1h = (addr_index == `G1_HIGH_INDEX);
  wire logic hit_g1l = (addr_index == `G1_LOW_INDEX);
  wire logic hit_ctrl = (addr_index == `CTRL_INDEX);
  wire logic hit_req = (addr_index == `REQ_INDEX);
  // A read whose address phase meets a write's data phase sees the new value
  wire logic [7:0] view_g0h = wr_g0h ? hwdata[7:0] : group0_enable_high;
  wire logic [7:0] view_g0l = wr_g0l ? hwdata[7:0] : group0_enable_low;
  wire logic [7:0] view_g1h = wr_g1h ? next_g1h : group1_enable_high;
  wire logic [7:0] view_g1l = wr_g1l ? next_g1l : group1_enable_low;
  wire logic view_gie = wr_ctrl ? hwdata[`CTRL_GIE_BIT] : global_enable;
  wire logic [7:0] sel_data =
    hit_g0h ? view_g0h :
    hit_g0l ? view_g0l :
    hit_g1h ? view_g1h :
    hit_g1l ? view_g1l :
    hit_ctrl ? {7'h00, view_gie} :
    8'h00;
  // Request view: group 1 in bits 15:8 above group 0, readable for polling
  wire logic [31:0] read_word = hit_req ?
    {16'h0000, request_group1, request_group0} : {24'h000000, sel_data};

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= rd ? read_word : 32'h00000000;
    end
  end

  // Zero wait states and OKAY only: every transfer ends after one data phase
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source fields
  // Group 0 high bits, timer 2 down to i2c
  wire logic timer2_prio_hi = group0_enable_high[7];
  wire logic timer1_prio_hi = group0_enable_high[6];
  wire logic timer0_prio_hi = group0_enable_high[5];
  wire logic serial0_rx_prio_hi = group0_enable_high[4];
  wire logic serial0_tx_prio_hi = group0_enable_high[3];
  wire logic usb_prio_hi = group0_enable_high[2];
  wire logic usb_wake_prio_hi = group0_enable_high[1];
  wire logic i2c_prio_hi = group0_enable_high[0];
  // Group 1 high bits, spi 1 down to rtc
  wire logic spi1_prio_hi = group1_enable_high[7];
  wire logic dac_prio_hi = group1_enable_high[6];
  wire logic dma_ch1_prio_hi = group1_enable_high[5];
  wire logic dma_ch0_prio_hi = group1_enable_high[4];
  wire logic adc_prio_hi = group1_enable_high[3];
  wire logic spi0_prio_hi = group1_enable_high[2];
  wire logic lcd_prio_hi = group1_enable_high[1];
  wire logic rtc_prio_hi = group1_enable_high[0];
  wire logic dac_prio_lo = group1_enable_low[6];

  // Each source's level from its own high and low bit
  wire logic [1:0] timer2_level = decode_prio(timer2_prio_hi, group0_enable_low[7]);
  wire logic [1:0] timer1_level = decode_prio(timer1_prio_hi, group0_enable_low[6]);
  wire logic [1:0] timer0_level = decode_prio(timer0_prio_hi, group0_enable_low[5]);
  wire logic [1:0] serial0_rx_level = decode_prio(serial0_rx_prio_hi, group0_enable_low[4]);
  wire logic [1:0] serial0_tx_level = decode_prio(serial0_tx_prio_hi, group0_enable_low[3]);
  wire logic [1:0] usb_level = decode_prio(usb_prio_hi, group0_enable_low[2]);
  wire logic [1:0] usb_wake_level = decode_prio(usb_wake_prio_hi, group0_enable_low[1]);
  wire logic [1:0] i2c_level = decode_prio(i2c_prio_hi, group0_enable_low[0]);

  wire logic [1:0] spi1_level = decode_prio(spi1_prio_hi, group1_enable_low[7]);
  wire logic [1:0] dac_level = decode_prio(dac_prio_hi, dac_prio_lo);
  wire logic [1:0] dma_ch1_level = decode_prio(dma_ch1_prio_hi, group1_enable_low[5]);
  wire logic [1:0] dma_ch0_level = decode_prio(dma_ch0_prio_hi, group1_enable_low[4]);
  wire logic [1:0] adc_level = decode_prio(adc_prio_hi, group1_enable_low[3]);
  wire logic [1:0] spi0_level = decode_prio(spi0_prio_hi, group1_enable_low[2]);
  wire logic [1:0] lcd_level = decode_prio(lcd_prio_hi, group1_enable_low[1]);
  wire logic [1:0] rtc_level = decode_prio(rtc_prio_hi, group1_enable_low[0]);

  ////////////////////////////////////////////////////////////////////////////
  // Priority outputs and arbitration
  wire logic [15:0] next_prio0 = {timer2_level, timer1_level, timer0_level, serial0_rx_level,
    serial0_tx_level, usb_level, usb_wake_level, i2c_level};
  wire logic [15:0] next_prio1 = {spi1_level, dac_level, dma_ch1_level, dma_ch0_level,
    adc_level, spi0_level, lcd_level, rtc_level};

  // Sources 0..7 are group 0 bits, 8..15 group 1 bits (13 dma1, 12 dma0)
  wire logic [5:0] best0 = pick_best(request_group0, next_prio0);
  wire logic [5:0] best1 = pick_best(request_group1, next_prio1);
  // Group 1 wins if group 0 has no candidate, else only with a strictly higher level
  wire logic take1 = best1[5] && (!best0[5] || (best1[1:0] > best0[1:0]));
  wire logic [3:0] best_src = take1 ? {1'b1, best1[4:2]} : {1'b0, best0[4:2]};
  wire logic [1:0] best_lvl = take1 ? best1[1:0] : best0[1:0];

  wire logic next_valid = global_enable && (best0[5] || best1[5]);

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      prio_group0 <= 16'h0000;
    end else begin
      prio_group0 <= next_prio0;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      prio_group1 <= 16'h0000;
    end else begin
      prio_group1 <= next_prio1;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      irq_valid <= 1'b0;
    end else begin
      irq_valid <= next_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      irq_source <= 4'h0;
      irq_level <= 2'b00;
    end else begin
      irq_source <= next_valid ? best_src : 4'h0;
      irq_level <= next_valid ? best_lvl : 2'b00;
    end
  end

endmodule : irq_enable_priority_regs

//--- sim/irq_prio_asserts.sv
// Checker on the block's ports.
// Assumes zero wait states and the bind below.
`timescale 1ns/100ps
module irq_prio_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] request_group0,
  input wire logic [7:0] request_group1,
  input wire logic [15:0] prio_group0,
  input wire logic [15:0] prio_group1,
  input wire logic irq_valid,
  input wire logic [3:0] irq_source,
  input wire logic [1:0] irq_level
);
  logic [15:0] req_q;
  always_ff @(posedge clk) begin
    req_q <= {request_group1, request_group0};
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_dac_locked: assert property (prio_group1[13:12] == 2'b00) else $error("dac on");
  a_idle_quiet: assert property (!irq_valid |-> irq_level == 0 && irq_source == 0)
    else $error("idle not zero");
  a_level_g0: assert property (irq_valid && !irq_source[3] |->
    irq_level == prio_group0[2*irq_source[2:0] +: 2]) else $error("group 0 level");
  a_level_g1: assert property (irq_valid && irq_source[3] |->
    irq_level == prio_group1[2*irq_source[2:0] +: 2]) else $error("group 1 level");
  a_winner_pending: assert property (irq_valid |-> req_q[irq_source])
    else $error("winner not pending");
  a_read_data_only: assert property (hrdata != 0 |->
    $past(hsel && hready && htrans[1] && !hwrite)) else $error("stray read data");
endmodule : irq_prio_asserts
bind irq_enable_priority_regs irq_prio_asserts i_chk (.clk, .rst_n, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .request_group0, .request_group1,
  .prio_group0, .prio_group1, .irq_valid, .irq_source, .irq_level);

//--- sim/irq_req_model.sv
// Request sources: raise the lines asked for.
// Assumes the block's clock.
`timescale 1ns/100ps
module irq_req_model (
  input wire logic clk,
  input wire logic [15:0] want,
  output logic [7:0] request_group0,
  output logic [7:0] request_group1
);
  always_ff @(posedge clk) begin
    {request_group1, request_group0} <= want;
  end
endmodule : irq_req_model

//--- sim/irq_enable_priority_regs_bench.sv
// Bench: bus tasks and scenarios.
// Assumes the model and checker files.
`timescale 1ns/100ps
`include "irq_prio_map.svh"
`define CK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module irq_enable_priority_regs_bench;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq_valid;
  logic [1:0] htrans = 0, irq_level;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [15:0] want = 0, prio_group0, prio_group1;
  logic [7:0] request_group0, request_group1;
  logic [3:0] irq_source;
  int mismatches = 0, n_compared = 0;
  always #2 clk = ~clk;
  irq_req_model i_req (.clk, .want, .request_group0, .request_group1);
  irq_enable_priority_regs i_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .request_group0,
    .request_group1, .prio_group0, .prio_group1, .irq_valid, .irq_source, .irq_level);
  task automatic bus(input logic [11:0] i, input logic w, input logic [31:0] d);
    hsel <= 1;
    haddr <= {18'h0, i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic t_reset;
    logic [11:0] r [5] = '{`G0_HIGH_INDEX, `G0_LOW_INDEX, `G1_HIGH_INDEX,
      `G1_LOW_INDEX, 12'hfc6};
    foreach (r[k]) begin
      bus(r[k], 0, 0);
      `CK(q, 32'h0)
    end
    `CK({prio_group0, prio_group1, irq_valid}, 33'h0)
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] h = 8'ha5, l = 8'h3c, gh = 8'hbf, gl = 8'h30;
    bus(`G0_HIGH_INDEX, 1, 32'ha5);
    bus(`G0_LOW_INDEX, 1, 32'h3c);
    bus(`G1_HIGH_INDEX, 1, 32'hff);
    bus(`G1_LOW_INDEX, 1, 32'h70);
    bus(`G0_HIGH_INDEX, 0, 0);
    `CK(q, 32'ha5)
    bus(`G0_LOW_INDEX, 0, 0);
    `CK(q, 32'h3c)
    bus(`G1_HIGH_INDEX, 0, 0);
    `CK(q, 32'hbf)
    bus(`G1_LOW_INDEX, 0, 0);
    `CK(q, 32'h30)
    repeat (3) @(posedge clk);
    `CK(prio_group1[11:8], 4'hf)
    for (int x = 0; x < 8; x++) begin
      `CK(prio_group0[2*x +: 2], {h[x], l[x]})
      `CK(prio_group1[2*x +: 2], {gh[x], gl[x]})
    end
  endtask : t_regs
  task automatic t_arb;
    logic [15:0] w [5] = '{16'h0081, 16'h8081, 16'h0003, 16'h0004, 16'h4100};
    logic [6:0] e [5] = '{7'h5e, 7'h7f, 7'h41, 7'h00, 7'h62};
    bus(`G0_HIGH_INDEX, 1, 32'h80);
    bus(`G0_LOW_INDEX, 1, 32'h03);
    bus(`G1_LOW_INDEX, 1, 32'h80);
    want <= 16'h0081;
    repeat (3) @(posedge clk);
    `CK(irq_valid, 1'b0)
    bus(`REQ_INDEX, 0, 0);
    `CK(q, 32'h81)
    bus(`CTRL_INDEX, 1, 32'h1);
    for (int k = 0; k < 5; k++) begin
      want <= w[k];
      repeat (3) @(posedge clk);
      `CK({irq_valid, irq_source, irq_level}, e[k])
    end
  endtask : t_arb
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_regs;
    t_arb;
    tally_and_finish;
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
endmodule : irq_enable_priority_regs_bench
